// >>> verilog/emc_pkg.sv
package emc_pkg;

  // register bus shape
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;

  // register offsets
  localparam logic [15:0] OFF_CLEAR       = 16'hf421;
  localparam logic [15:0] OFF_PARITY_MASK = 16'hf422;
  localparam logic [15:0] OFF_SW_MASK     = 16'hf423;
  localparam logic [15:0] OFF_WD_MASK     = 16'hf424;
  localparam logic [15:0] OFF_STACK_MASK  = 16'hf425;
  localparam logic [15:0] OFF_LOOP_MASK   = 16'hf426;
  localparam logic [15:0] OFF_FLAG        = 16'hf427;
  localparam logic [15:0] OFF_CODE        = 16'hf428;
  localparam logic [15:0] OFF_IRQ_STATUS  = 16'hf430;
  localparam logic [15:0] OFF_IRQ_MASK    = 16'hf431;

  // reset values
  localparam logic [15:0] RST_CLEAR       = 16'h0000;
  localparam logic [15:0] RST_PARITY_MASK = 16'h0003;
  localparam logic [15:0] RST_SW_MASK     = 16'h0000;
  localparam logic [15:0] RST_WD_MASK     = 16'h0000;
  localparam logic [15:0] RST_STACK_MASK  = 16'h0000;
  localparam logic [15:0] RST_LOOP_MASK   = 16'h0000;
  localparam logic [15:0] RST_CODE        = 16'h0000;
  localparam logic [15:0] RST_IRQ_MASK    = 16'h0000;

  // parity mask field positions
  localparam int          PAR_RC_LSB      = 0;   // rate converter mem 0..1
  localparam int          PAR_PM_A        = 2;
  localparam int          PAR_PM_B        = 3;
  localparam int          PAR_DM_A_LSB    = 4;   // data mem a banks 0..3
  localparam int          PAR_DM_B_LSB    = 8;   // data mem b banks 0..3
  localparam int          PAR_SRC_N       = 12;

  // error code bit positions
  localparam int          CODE_WATCHDOG   = 12;
  localparam int          CODE_STACK      = 13;
  localparam int          CODE_LOOP       = 14;
  localparam int          CODE_SOFT       = 15;

  // interrupt status bits
  localparam int          IRQ_FIRST_ERR   = 0;   // first unmasked error since reset or clear
  localparam int          IRQ_CLEARED     = 1;   // manager cleared
  localparam int          IRQ_N           = 2;

  // stereo rate converters, per memory bank and in total
  localparam int          RC_PER_BANK     = 4;
  localparam int          RC_N            = 8;

endpackage : emc_pkg

// >>> verilog/emc_edge_det.sv
`timescale 1ns/100ps
// rising edge finder on a register bit of the same clock domain
module emc_edge_det
  import emc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in, pulse out
  input  wire logic level_in,
  output logic      rise_pulse
);

  logic prev_r;

  // previous value, reset matches the clear register reset of zero
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_in;
    end
  end

  // steady 0 or 1 gives nothing
  assign rise_pulse = level_in & ~prev_r;

endmodule : emc_edge_det

// >>> verilog/emc_error_manager.sv
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
// How it works
// [R1] rising edge of clear bit 0 clears master flag and manager state
// [R2] software writes clear bit 1 then 0 so next clear needs an edge
// [R3] parity mask holds one bit per bank of both data memories
// [R4] bits 11..8 mask data memory b banks 3..0; 1 suppresses
// [R5] bits 7..4 mask data memory a banks 3..0; 1 suppresses
// [R6] bit 3 masks program memory b, bit 2 program memory a
// [R7] bits 1..0 mask rate converter memories; register resets to 0x0003
// [R8] stereo converters 0-3 use memory bank 0, 4-7 use bank 1
// [R9] software mask bit 0: 0 reports software errors, 1 ignores
// [R10] watchdog mask bit 0: 0 reports watchdog errors, 1 ignores
// [R11] unused upper bits are reserved, read-write, reset zero
// [R12] unmasked error sets sticky read-only master flag until clear
// [R13] error code keeps only the first reported error until clear
// [R14] stack and loop masks: 0 reports, 1 ignores, reset 0
// [R15] clear edge found synchronously; masked sources touch nothing
module emc_error_manager
  import emc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // parity error pulses from memories
  input  wire logic [3:0]        data_memory_a_err,
  input  wire logic [3:0]        data_memory_b_err,
  input  wire logic              program_memory_a_err,
  input  wire logic              program_memory_b_err,
  input  wire logic [RC_N-1:0]   rate_converter_err,
  // other error sources
  input  wire logic              software_err,
  input  wire logic              watchdog_err,
  input  wire logic              stack_err,
  input  wire logic              loop_err,
  // status out
  output logic                   error_flag,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [DATA_W-1:0] clear_r;
  logic [DATA_W-1:0] parity_mask_r;
  logic [DATA_W-1:0] sw_mask_r;
  logic [DATA_W-1:0] wd_mask_r;
  logic [DATA_W-1:0] stack_mask_r;
  logic [DATA_W-1:0] loop_mask_r;
  logic              flag_r;
  logic [DATA_W-1:0] code_r;
  logic [IRQ_N-1:0]  irq_status_r;
  logic [IRQ_N-1:0]  irq_mask_r;
  logic [DATA_W-1:0] rdata_r;

  logic              clear_pulse;
  logic [1:0]        rc_bank_err;
  logic [DATA_W-1:0] raw_err;
  logic [DATA_W-1:0] src_mask;
  logic [DATA_W-1:0] live_err;
  logic              any_err;
  logic [IRQ_N-1:0]  irq_event;
  logic [IRQ_N-1:0]  irq_status_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // write side of the mask and clear registers

  // clear and source mask registers keep all bits as written, reserved bits included; the irq mask keeps only its IRQ_N bits
  always_ff @(posedge clk) begin
    if (rst) begin
      clear_r       <= RST_CLEAR;        // R11
      parity_mask_r <= RST_PARITY_MASK;  // R7
      sw_mask_r     <= RST_SW_MASK;      // R9
      wd_mask_r     <= RST_WD_MASK;      // R10
      stack_mask_r  <= RST_STACK_MASK;   // R14
      loop_mask_r   <= RST_LOOP_MASK;    // R14
      irq_mask_r    <= RST_IRQ_MASK[IRQ_N-1:0];
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_CLEAR:       clear_r       <= reg_wdata;  // R11
        OFF_PARITY_MASK: parity_mask_r <= reg_wdata;  // R3
        OFF_SW_MASK:     sw_mask_r     <= reg_wdata;  // R9
        OFF_WD_MASK:     wd_mask_r     <= reg_wdata;  // R10
        OFF_STACK_MASK:  stack_mask_r  <= reg_wdata;  // R14
        OFF_LOOP_MASK:   loop_mask_r   <= reg_wdata;  // R14
        OFF_IRQ_MASK:    irq_mask_r    <= reg_wdata[IRQ_N-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clear edge

  // the host must return the bit to 0 before another clear can fire
  emc_edge_det u_clear_edge (
    .clk        (clk),
    .rst        (rst),
    .level_in   (clear_r[0]),
    .rise_pulse (clear_pulse)
  ); // R1 R2 R15

  ////////////////////////////////////////////////////////////////////////////
  // error sources

  // stereo converters share two memory banks, four per bank
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_rc_bank
      assign rc_bank_err[gi] = |rate_converter_err[gi*RC_PER_BANK +: RC_PER_BANK]; // R8
    end
  endgenerate

  // raw errors laid out as the error code register
  always_comb begin
    raw_err                                = '0;
    raw_err[PAR_RC_LSB +: 2]               = rc_bank_err;
    raw_err[PAR_PM_A]                      = program_memory_a_err;
    raw_err[PAR_PM_B]                      = program_memory_b_err;
    raw_err[PAR_DM_A_LSB +: 4]             = data_memory_a_err;
    raw_err[PAR_DM_B_LSB +: 4]             = data_memory_b_err;
    raw_err[CODE_WATCHDOG]                 = watchdog_err;
    raw_err[CODE_STACK]                    = stack_err;
    raw_err[CODE_LOOP]                     = loop_err;
    raw_err[CODE_SOFT]                     = software_err;
  end

  // mask in the same layout; a 1 suppresses the source
  always_comb begin
    src_mask                               = '0;
    src_mask[PAR_SRC_N-1:0]                = parity_mask_r[PAR_SRC_N-1:0]; // R4 R5 R6 R7
    src_mask[CODE_WATCHDOG]                = wd_mask_r[0];     // R10
    src_mask[CODE_STACK]                   = stack_mask_r[0];  // R14
    src_mask[CODE_LOOP]                    = loop_mask_r[0];   // R14
    src_mask[CODE_SOFT]                    = sw_mask_r[0];     // R9
  end

  assign live_err = raw_err & ~src_mask;  // R15
  assign any_err  = |live_err;

  ////////////////////////////////////////////////////////////////////////////
  // manager state: master flag and first error code

  // an error in the clear cycle wins: it opens the next episode, so a
  // one-cycle parity pulse that meets the clear edge is not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (any_err) begin
      flag_r <= 1'b1;  // R12
    end else if (clear_pulse) begin
      flag_r <= 1'b0;  // R1
    end
  end

  // only the first report is kept; several sources in that one cycle all show
  always_ff @(posedge clk) begin
    if (rst) begin
      code_r <= RST_CODE;
    end else if (any_err && (!flag_r || clear_pulse)) begin
      code_r <= live_err;  // R13
    end else if (clear_pulse) begin
      code_r <= RST_CODE;  // R1
    end
  end

  assign error_flag = flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins

  assign irq_event[IRQ_FIRST_ERR] = any_err & (~flag_r | clear_pulse);
  assign irq_event[IRQ_CLEARED]   = clear_pulse;

  always_comb begin
    irq_status_nxt = irq_status_r;
    if (reg_wr && reg_addr == OFF_IRQ_STATUS) begin
      irq_status_nxt = irq_status_nxt & ~reg_wdata[IRQ_N-1:0];
    end
    irq_status_nxt = irq_status_nxt | irq_event;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // read side, data one cycle after the strobe; unmapped reads give zero

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_CLEAR:       rdata_r <= clear_r;
        OFF_PARITY_MASK: rdata_r <= parity_mask_r;
        OFF_SW_MASK:     rdata_r <= sw_mask_r;
        OFF_WD_MASK:     rdata_r <= wd_mask_r;
        OFF_STACK_MASK:  rdata_r <= stack_mask_r;
        OFF_LOOP_MASK:   rdata_r <= loop_mask_r;
        OFF_FLAG:        rdata_r <= {{(DATA_W-1){1'b0}}, flag_r};  // R12
        OFF_CODE:        rdata_r <= code_r;  // R13
        OFF_IRQ_STATUS:  rdata_r <= {{(DATA_W-IRQ_N){1'b0}}, irq_status_r};
        OFF_IRQ_MASK:    rdata_r <= {{(DATA_W-IRQ_N){1'b0}}, irq_mask_r};
        default:         rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : emc_error_manager

// >>> testbench/emc_error_manager_chk.sv
`timescale 1ns/100ps
// port-level checks on flag, code and read-back timing
module emc_error_manager_chk
  import emc_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // error sources
  input wire logic [3:0]        data_memory_a_err,
  input wire logic [3:0]        data_memory_b_err,
  input wire logic              program_memory_a_err,
  input wire logic              program_memory_b_err,
  input wire logic [RC_N-1:0]   rate_converter_err,
  input wire logic              software_err,
  input wire logic              watchdog_err,
  input wire logic              stack_err,
  input wire logic              loop_err,
  // status
  input wire logic              error_flag,
  input wire logic              irq
);
  //////////////////////////////
  // raw activity before masking; a masked source may still toggle this
  logic any_err;
  assign any_err = |{data_memory_a_err, data_memory_b_err, program_memory_a_err,
    program_memory_b_err, rate_converter_err, software_err, watchdog_err, stack_err, loop_err};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////
  rst_quiet_a:
    assert property (disable iff (1'b0) rst |=> !error_flag && !irq && reg_rdata == 16'h0000)
      else $error("outputs busy after reset");
  rd_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
  flag_rise_a:
    assert property ($rose(error_flag) |-> $past(any_err)) else $error("flag set with no error");
  flag_fall_a:
    assert property ($fell(error_flag) |->
      $past(reg_wr && reg_addr == OFF_CLEAR && reg_wdata[0], 2))
      else $error("flag dropped without clear");
  flag_read_a:
    assert property (reg_rd && reg_addr == OFF_FLAG |=> reg_rdata == {15'h0000, $past(error_flag)})
      else $error("flag read wrong");
  code_read_a:
    assert property (reg_rd && reg_addr == OFF_CODE |=>
      (reg_rdata != 16'h0000) == $past(error_flag))
      else $error("code and flag disagree");
  irq_rise_a:
    assert property ($rose(irq) |-> $past(reg_wr) || $past(reg_wr, 2) || $rose(error_flag))
      else $error("irq rose without cause");
  mask_rw_a:
    assert property (reg_wr && reg_addr >= OFF_CLEAR && reg_addr <= OFF_LOOP_MASK ##2
      reg_rd && reg_addr == $past(reg_addr, 2) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("mask readback wrong");
endmodule : emc_error_manager_chk

bind emc_error_manager emc_error_manager_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .data_memory_a_err(data_memory_a_err), .data_memory_b_err(data_memory_b_err),
  .program_memory_a_err(program_memory_a_err), .program_memory_b_err(program_memory_b_err),
  .rate_converter_err(rate_converter_err), .software_err(software_err),
  .watchdog_err(watchdog_err), .stack_err(stack_err), .loop_err(loop_err),
  .error_flag(error_flag), .irq(irq));

// >>> testbench/test_error_manager_masks_clear.sv
`timescale 1ns/100ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin fail_count++; \
  $display("wrong value at %0t: %h not %h", $time, g, x); end end
// the read task queues expected read data; a monitor compares it
module test_error_manager_masks_clear
  import emc_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic        pma = 1'b0, pmb = 1'b0, sw = 1'b0, wd = 1'b0, stk = 1'b0, lp = 1'b0;
  logic        flag, irq;
  logic [3:0]  dma = 4'h0, dmb = 4'h0;
  logic [7:0]  rc = 8'h00;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, e, one_m;
  logic [15:0] exp_q[$];
  int          fail_count = 0, checks_done = 0, seed = 74, r;

  emc_error_manager u_emc_error_manager (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_memory_a_err(dma), .data_memory_b_err(dmb), .program_memory_a_err(pma),
    .program_memory_b_err(pmb), .rate_converter_err(rc), .software_err(sw),
    .watchdog_err(wd), .stack_err(stk), .loop_err(lp), .error_flag(flag), .irq(irq));

  //////////////////////////////
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;

  // one-cycle strobes with a gap, so no signal is assigned twice per edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(x);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // code bit order onto the source pins; converter picked at random inside its bank
  task automatic src(input logic [15:0] v);
    r = $random(seed);
    rc <= {v[1] ? 4'h1 << r[3:2] : 4'h0, v[0] ? 4'h1 << r[1:0] : 4'h0};
    {sw, lp, stk, wd, dmb, dma, pmb, pma} <= v[15:2];
  endtask : src
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    src(v);
    @(posedge clk);
    src(16'h0000);
  endtask : pulse
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  //////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) if (rd_seen) begin
    e = exp_q.pop_front();
    `CHK(reg_rdata, e)
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(16'(OFF_CLEAR + i), i == 1 ? RST_PARITY_MASK : 16'h0000);
    rd(16'h0000, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      wr(16'(OFF_CLEAR + i), r[15:0]);
      rd(16'(OFF_CLEAR + i), r[15:0]);
    end
    for (int i = 0; i < 6; i++) wr(16'(OFF_CLEAR + i), 16'h0000);
    wr(OFF_IRQ_MASK, 16'h0001);
    // each source alone, then a later one that must not reach the code
    for (int i = 0; i < 16; i++) begin
      wr(OFF_CLEAR, 16'h0001);
      wr(OFF_CLEAR, 16'h0000);
      rd(OFF_IRQ_STATUS, 16'h0002);
      pulse(16'h0001 << i);
      pulse(16'h0001 << ((i + 1) % 16));
      rd(OFF_FLAG, 16'h0001);
      rd(OFF_CODE, 16'h0001 << i);
      @(negedge clk);
      `CHK(irq, 1'b1)
      `CHK(flag, 1'b1)
      wr(OFF_IRQ_STATUS, 16'h0003);
      @(negedge clk);
      `CHK(irq, 1'b0)
    end
    // a steady one and a falling edge must not clear
    wr(OFF_CLEAR, 16'h0001);
    pulse(16'h8000);
    wr(OFF_CLEAR, 16'h0001);
    rd(OFF_FLAG, 16'h0001);
    wr(OFF_CLEAR, 16'h0000);
    rd(OFF_FLAG, 16'h0001);
    // one source masked at a time while all fire; catches a mask bit on the wrong source
    for (int i = 0; i < 16; i++) begin
      one_m = 16'h0001 << i;
      wr(OFF_PARITY_MASK, one_m & 16'h0fff);
      wr(OFF_WD_MASK, {15'h0000, one_m[12]});
      wr(OFF_STACK_MASK, {15'h0000, one_m[13]});
      wr(OFF_LOOP_MASK, {15'h0000, one_m[14]});
      wr(OFF_SW_MASK, {15'h0000, one_m[15]});
      wr(OFF_CLEAR, 16'h0001);
      wr(OFF_CLEAR, 16'h0000);
      pulse(16'hffff);
      rd(OFF_CODE, ~one_m);
    end
    // everything masked: nothing may be reported
    wr(OFF_PARITY_MASK, 16'h0fff);
    for (int i = 2; i < 6; i++) wr(16'(OFF_CLEAR + i), 16'h0001);
    wr(OFF_CLEAR, 16'h0001);
    wr(OFF_CLEAR, 16'h0000);
    pulse(16'hffff);
    rd(OFF_FLAG, 16'h0000);
    rd(OFF_CODE, 16'h0000);
    @(negedge clk);
    `CHK(flag, 1'b0)
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule : test_error_manager_masks_clear
